// [rtl/sep_consts.svh]
// Constants shared by both ends of the serial memory command port.
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH

`define SEP_WORD_W        16
`define SEP_ADDR_W        8
`define SEP_MODE_W        8
`define SEP_DEPTH         256
`define SEP_START_PAT     4'ha
`define SEP_OPC_READ      4'h8
`define SEP_OPC_WRITE     4'h4
`define SEP_OPC_ENABLE    4'h3
`define SEP_OPC_DISABLE   4'h0
`define SEP_OPC_ERASE     4'h2
`define SEP_OPC_FILL      4'h1
`define SEP_ERASED_WORD   16'hffff
`define SEP_BITS_MODE     6'h08
`define SEP_BITS_CMD      6'h10
`define SEP_BITS_DATA     6'h20
`define SEP_BITS_READ     6'h21
`define SEP_CLK_MHZ       50
`define SEP_PROG_TIME_MS  10
`define SEP_PROG_CYCLES   (`SEP_PROG_TIME_MS * 1000 * `SEP_CLK_MHZ)
`define SEP_HALF_CYCLES   8
`define SEP_GUARD_TICKS   4'h4

`endif

// [rtl/sep_pkg.sv]
// Types shared by both ends of the serial memory command port.
`default_nettype none
package sep_pkg;
	typedef enum logic [2:0] {
		SEP_OP_NONE    = 3'h0,
		SEP_OP_READ    = 3'h1,
		SEP_OP_WRITE   = 3'h2,
		SEP_OP_ENABLE  = 3'h3,
		SEP_OP_DISABLE = 3'h4,
		SEP_OP_ERASE   = 3'h5,
		SEP_OP_FILL    = 3'h6
	} sep_op_t;

	typedef enum logic [4:0] {
		SEP_DS_IDLE   = 5'h01,
		SEP_DS_SHIFT  = 5'h02,
		SEP_DS_READ   = 5'h04,
		SEP_DS_PROG   = 5'h08,
		SEP_DS_IGNORE = 5'h10
	} sep_dev_state_t;

	typedef enum logic [3:0] {
		SEP_HS_IDLE  = 4'h1,
		SEP_HS_SHIFT = 4'h2,
		SEP_HS_WAIT  = 4'h4,
		SEP_HS_GAP   = 4'h8
	} sep_host_state_t;
endpackage
`default_nettype wire

// [rtl/sep_if.sv]
// Pin-level link between the serial memory and its host controller.
`default_nettype none
interface sep_if;
	logic chip_select;
	logic serial_clock;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	logic ready_busy;
	logic reset_pin;

	modport dev (
		input  chip_select, serial_clock, serial_in, reset_pin,
		output serial_out, serial_out_oe, ready_busy
	);
	modport host (
		output chip_select, serial_clock, serial_in, reset_pin,
		input  serial_out, serial_out_oe, ready_busy
	);
endinterface
`default_nettype wire

// [rtl/sep_device.sv]
// Serial memory device end: frame decoder, 256x16 array, self-timed programming.
//
// Functional notes
// (RL1) Sample input on rise, drive output on fall.
// (RL2) Frame is mode byte, address byte, data.
// (RL3) Array holds 256 words of 16 bits.
// (RL4) Mode is start 1010 plus 4-bit opcode.
// (RL5) Power up with programming disabled until enable.
// (RL6) Disable opcode blocks programming again.
// (RL7) Enable state gates only write and erase; the code gates fill all as well.
// (RL8) Only read drives output, word shifted out.
// (RL9) Write programming starts after 32nd rising edge.
// (RL10) Word write erases the word first.
// (RL11) Busy shown for whole programming cycle.
// (RL12) Programming is timed on chip, no clock.
// (RL13) Reset pin high aborts any operation.
// (RL14) Erase all sets every bit to one.
// (RL15) Fill all takes 16 data bits for all words.
// (RL16) Host should erase all before fill all.
// (RL17) Fill all overwrites every word at once.
// (RL18) Programming cycle ends within 10 ms.
// (RL19) Read gives dummy bit then LSB first.
// (RL20) Unknown mode byte is ignored entirely.
`include "sep_consts.svh"
`default_nettype none
module sep_device #(
	parameter int unsigned PROG_CYCLES = `SEP_PROG_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	sep_if.dev        link,
	output logic      busy_o,
	output logic      prog_enabled_o,
	output sep_pkg::sep_op_t last_op_o
);
	import sep_pkg::*;

	// Classifies a received mode byte; bit 0 of the frame is the first bit on the wire.
	function automatic sep_op_t decode_mode(input logic [7:0] m);
		logic [3:0] start;
		logic [3:0] opc;
		start = {m[0], m[1], m[2], m[3]};
		opc   = {m[4], m[5], m[6], m[7]};
		decode_mode = SEP_OP_NONE;
		if (start == `SEP_START_PAT) begin // RL4
			case (opc)
				`SEP_OPC_READ:    decode_mode = SEP_OP_READ;
				`SEP_OPC_WRITE:   decode_mode = SEP_OP_WRITE;
				`SEP_OPC_ENABLE:  decode_mode = SEP_OP_ENABLE;
				`SEP_OPC_DISABLE: decode_mode = SEP_OP_DISABLE;
				`SEP_OPC_ERASE:   decode_mode = SEP_OP_ERASE;
				`SEP_OPC_FILL:    decode_mode = SEP_OP_FILL;
				default:          decode_mode = SEP_OP_NONE;
			endcase
		end
	endfunction

	logic [1:0]                 sclk_sync;
	logic [1:0]                 cs_sync;
	logic [1:0]                 si_sync;
	logic [1:0]                 abort_sync;
	logic                       sclk_prev;
	logic                       sclk_rise;
	logic                       sclk_fall;
	logic                       selected;
	logic                       abort;
	sep_dev_state_t             state;
	logic [5:0]                 bit_cnt;
	logic [31:0]                rx;
	sep_op_t                    op;
	logic                       prog_en;
	logic                       start_prog;
	logic                       prog_done;
	logic [31:0]                prog_timer;
	sep_op_t                    prog_op;
	logic [`SEP_ADDR_W-1:0]     prog_addr;
	logic [`SEP_WORD_W-1:0]     prog_data;
	logic [`SEP_WORD_W:0]       out_sh;
	logic                       so;
	logic                       so_oe;
	logic                       ready;
	logic [`SEP_WORD_W-1:0]     mem [`SEP_DEPTH];
	logic                       load_read;

	// Every pin comes from the host's domain, so each passes two flip-flops first.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_sync  <= 2'h0;
			cs_sync    <= 2'h0;
			si_sync    <= 2'h0;
			abort_sync <= 2'h0;
			sclk_prev  <= 1'b0;
		end else begin
			sclk_sync  <= {sclk_sync[0], link.serial_clock};
			cs_sync    <= {cs_sync[0], link.chip_select};
			si_sync    <= {si_sync[0], link.serial_in};
			abort_sync <= {abort_sync[0], link.reset_pin};
			sclk_prev  <= sclk_sync[1];
		end
	end

	// Edges of the serial clock as seen in our domain.
	assign sclk_rise = sclk_sync[1] & ~sclk_prev;
	assign sclk_fall = ~sclk_sync[1] & sclk_prev;
	assign selected  = cs_sync[1];
	assign abort     = abort_sync[1];
	assign op        = decode_mode(rx[7:0]);

	// Programming starts at the end of the byte that completes the command, only when enabled.
	assign start_prog = (state == SEP_DS_SHIFT) && selected && prog_en &&
		(((bit_cnt == `SEP_BITS_CMD) && (op == SEP_OP_ERASE)) || // RL14
		 ((bit_cnt == `SEP_BITS_DATA) && ((op == SEP_OP_WRITE) || (op == SEP_OP_FILL)))); // RL9 RL15 RL5
	assign prog_done  = (state == SEP_DS_PROG) && (prog_timer == PROG_CYCLES - 1); // RL18
	assign load_read  = (state == SEP_DS_SHIFT) && selected && (bit_cnt == `SEP_BITS_CMD) &&
		(op == SEP_OP_READ); // RL7

	// Frame sequencer; the reset pin drops whatever is in flight at once.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state   <= SEP_DS_IDLE;
			bit_cnt <= 6'h00;
		end else if (abort) begin
			state   <= SEP_DS_IDLE; // RL13
			bit_cnt <= 6'h00;
		end else begin
			unique case (state)
				SEP_DS_IDLE: begin
					bit_cnt <= 6'h00;
					if (selected) begin
						state <= SEP_DS_SHIFT;
					end
				end
				SEP_DS_SHIFT: begin
					if (!selected) begin
						state <= SEP_DS_IDLE;
					end else if (start_prog) begin
						state <= SEP_DS_PROG;
					end else if (load_read) begin
						state <= SEP_DS_READ; // RL8
					end else if ((bit_cnt == `SEP_BITS_MODE) && (op == SEP_OP_NONE)) begin
						state <= SEP_DS_IGNORE; // RL20
					end else if ((bit_cnt == `SEP_BITS_CMD) && (op != SEP_OP_WRITE) && (op != SEP_OP_FILL)) begin
						state <= SEP_DS_IGNORE; // RL2
					end else if (bit_cnt == `SEP_BITS_DATA) begin
						state <= SEP_DS_IGNORE; // RL5
					end else if (sclk_rise) begin
						bit_cnt <= bit_cnt + 6'h01; // RL1
					end
				end
				SEP_DS_READ: begin
					if (!selected) begin
						state <= SEP_DS_IDLE;
					end
				end
				SEP_DS_PROG: begin
					// The serial clock plays no part here; only the local timer or the reset pin ends the cycle.
					if (prog_done) begin
						state <= SEP_DS_IGNORE; // RL12
					end
				end
				SEP_DS_IGNORE: begin
					if (!selected) begin
						state <= SEP_DS_IDLE;
					end
				end
			endcase
		end
	end

	// Input shift: each rising edge stores the bit at its position in the frame.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx <= 32'h0000_0000;
		end else if (state == SEP_DS_IDLE) begin
			rx <= 32'h0000_0000;
		end else if ((state == SEP_DS_SHIFT) && sclk_rise && (bit_cnt < `SEP_BITS_DATA)) begin
			rx[bit_cnt[4:0]] <= si_sync[1]; // RL1 RL2
		end
	end

	// Write protection lives until power goes; the reset pin does not touch it.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_en <= 1'b0; // RL5
		end else if ((state == SEP_DS_SHIFT) && selected && !abort && (bit_cnt == `SEP_BITS_CMD)) begin
			if (op == SEP_OP_ENABLE) begin
				prog_en <= 1'b1; // RL5
			end else if (op == SEP_OP_DISABLE) begin
				prog_en <= 1'b0; // RL6
			end
		end
	end

	// Self-timed programming counter and the command it serves.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_timer <= 32'h0000_0000;
			prog_op    <= SEP_OP_NONE;
			prog_addr  <= 8'h00;
			prog_data  <= 16'h0000;
		end else if (start_prog && !abort) begin
			prog_timer <= 32'h0000_0000;
			prog_op    <= op;
			prog_addr  <= rx[15:8];
			prog_data  <= rx[31:16];
		end else if ((state == SEP_DS_PROG) && !abort) begin
			prog_timer <= prog_timer + 32'h0000_0001; // RL12
		end
	end

	// Array update: erase happens when the cycle starts, new data lands when it ends.
	// An aborted word write therefore leaves the word erased, as a real cell would.
	always_ff @(posedge clk_i) begin
		if (start_prog && !abort) begin
			if (op == SEP_OP_WRITE) begin
				mem[rx[15:8]] <= `SEP_ERASED_WORD; // RL10
			end else if (op == SEP_OP_ERASE) begin
				for (int i = 0; i < `SEP_DEPTH; i++) begin
					mem[i] <= `SEP_ERASED_WORD; // RL14
				end
			end
		end else if (prog_done && !abort) begin
			if (prog_op == SEP_OP_WRITE) begin
				mem[prog_addr] <= prog_data; // RL3 RL10
			end else if (prog_op == SEP_OP_FILL) begin
				for (int i = 0; i < `SEP_DEPTH; i++) begin
					mem[i] <= prog_data; // RL17
				end
			end
		end
	end

	// Read output: a zero dummy bit leads, then data least significant bit first.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_sh <= 17'h0_0000;
			so     <= 1'b0;
			so_oe  <= 1'b0;
		end else if (abort || (state != SEP_DS_READ && !load_read)) begin
			so_oe <= 1'b0; // RL19
			so    <= 1'b0;
		end else if (load_read) begin
			out_sh <= {mem[rx[15:8]], 1'b0}; // RL8 RL19
		end else if (sclk_fall) begin
			so     <= out_sh[0]; // RL1
			so_oe  <= 1'b1; // RL8
			out_sh <= {1'b0, out_sh[`SEP_WORD_W:1]};
		end
	end

	// Ready/busy tracks the programming state machine, high meaning ready.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ready <= 1'b1;
		end else if (abort) begin
			ready <= 1'b1;
		end else begin
			ready <= !(start_prog || ((state == SEP_DS_PROG) && !prog_done)); // RL11
		end
	end

	assign link.serial_out    = so;
	assign link.serial_out_oe = so_oe;
	assign link.ready_busy    = ready;

	// Local status mirrors for the system around the memory.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_op_o <= SEP_OP_NONE;
		end else if ((state == SEP_DS_SHIFT) && (bit_cnt == `SEP_BITS_MODE)) begin
			last_op_o <= op;
		end
	end

	assign busy_o         = ~ready;
	assign prog_enabled_o = prog_en;
endmodule
`default_nettype wire

// [rtl/sep_host.sv]
// Host end: builds command frames, drives the serial clock, buffers read words.
`include "sep_consts.svh"
`default_nettype none
module sep_host #(
	parameter int unsigned HALF_CYCLES = `SEP_HALF_CYCLES
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	sep_if.host                   link,
	input  wire logic             cmd_valid_i,
	output logic                  cmd_ready_o,
	input  wire sep_pkg::sep_op_t cmd_op_i,
	input  wire logic [7:0]       cmd_addr_i,
	input  wire logic [15:0]      cmd_data_i,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic [15:0]           rd_data_o,
	input  wire logic             abort_i,
	output logic                  busy_o
);
	import sep_pkg::*;

	// Opcode for each command; the start pattern is prepended by the caller.
	function automatic logic [3:0] opcode_of(input sep_op_t o);
		unique case (o)
			SEP_OP_READ:    opcode_of = `SEP_OPC_READ;
			SEP_OP_WRITE:   opcode_of = `SEP_OPC_WRITE;
			SEP_OP_ENABLE:  opcode_of = `SEP_OPC_ENABLE;
			SEP_OP_DISABLE: opcode_of = `SEP_OPC_DISABLE;
			SEP_OP_ERASE:   opcode_of = `SEP_OPC_ERASE;
			SEP_OP_FILL:    opcode_of = `SEP_OPC_FILL;
			default:        opcode_of = 4'hf;
		endcase
	endfunction

	logic [1:0]      so_sync;
	logic [1:0]      rb_sync;
	logic [31:0]     half_cnt;
	logic            tick;
	sep_host_state_t state;
	logic [32:0]     tx;
	logic [5:0]      nbits;
	logic [5:0]      rise_cnt;
	logic            is_read;
	logic            is_prog;
	logic [3:0]      guard;
	logic [16:0]     rd_sh;
	logic            cs;
	logic            sclk;
	logic            si;
	logic            push;
	logic [15:0]     fifo [2];
	logic            wr_ptr;
	logic            rd_ptr;
	logic [1:0]      fifo_cnt;
	logic [7:0]      mode;

	// Device outputs arrive from outside our timing, so they are synchronised first.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			so_sync <= 2'h0;
			rb_sync <= 2'h3;
		end else begin
			so_sync <= {so_sync[0], link.serial_out};
			rb_sync <= {rb_sync[0], link.ready_busy};
		end
	end

	// Half-period divider producing one enable pulse per serial clock edge.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_cnt <= 32'h0000_0000;
		end else if (tick || state == SEP_HS_IDLE) begin
			half_cnt <= 32'h0000_0000;
		end else begin
			half_cnt <= half_cnt + 32'h0000_0001;
		end
	end
	assign tick = (half_cnt == HALF_CYCLES - 1);

	// Mode bits go out start pattern first, most significant bit of each nibble first.
	assign mode        = {opcode_of(cmd_op_i), `SEP_START_PAT};
	assign cmd_ready_o = (state == SEP_HS_IDLE) && (fifo_cnt != 2'h2) && !abort_i;
	assign push        = (state == SEP_HS_SHIFT) && tick && sclk && (rise_cnt == nbits) && is_read;

	// Frame engine: data changes while the clock is low, read data is taken before each rise.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state    <= SEP_HS_IDLE;
			tx       <= 33'h0_0000_0000;
			nbits    <= 6'h00;
			rise_cnt <= 6'h00;
			is_read  <= 1'b0;
			is_prog  <= 1'b0;
			guard    <= 4'h0;
			rd_sh    <= 17'h0_0000;
			cs       <= 1'b0;
			sclk     <= 1'b0;
			si       <= 1'b0;
		end else if (abort_i) begin
			state <= SEP_HS_IDLE;
			cs    <= 1'b0;
			sclk  <= 1'b0;
			si    <= 1'b0;
		end else begin
			unique case (state)
				SEP_HS_IDLE: begin
					if (cmd_valid_i && cmd_ready_o) begin
						tx       <= {1'b0, cmd_data_i, cmd_addr_i, mode[4], mode[5], mode[6], mode[7],
							mode[0], mode[1], mode[2], mode[3]}; // RL2 RL4
						is_read  <= (cmd_op_i == SEP_OP_READ);
						is_prog  <= (cmd_op_i == SEP_OP_WRITE) || (cmd_op_i == SEP_OP_ERASE) ||
							(cmd_op_i == SEP_OP_FILL);
						nbits    <= (cmd_op_i == SEP_OP_READ) ? `SEP_BITS_READ :
							((cmd_op_i == SEP_OP_WRITE) || (cmd_op_i == SEP_OP_FILL)) ? `SEP_BITS_DATA :
							`SEP_BITS_CMD; // RL9 RL15
						si       <= mode[3];
						rise_cnt <= 6'h00;
						cs       <= 1'b1;
						sclk     <= 1'b0;
						state    <= SEP_HS_SHIFT;
					end
				end
				SEP_HS_SHIFT: begin
					if (tick && !sclk) begin
						sclk     <= 1'b1;
						rise_cnt <= rise_cnt + 6'h01;
						if (is_read && (rise_cnt >= `SEP_BITS_CMD)) begin
							rd_sh <= {so_sync[1], rd_sh[16:1]}; // RL1
						end
					end else if (tick) begin
						sclk <= 1'b0;
						if (rise_cnt == nbits) begin
							cs    <= 1'b0;
							si    <= 1'b0;
							guard <= 4'h0;
							state <= is_prog ? SEP_HS_WAIT : SEP_HS_GAP;
						end else begin
							si <= tx[rise_cnt]; // RL1
						end
					end
				end
				SEP_HS_WAIT: begin
					// Give the device time to show busy before trusting a ready level.
					if (tick && guard != `SEP_GUARD_TICKS) begin // RL12
						guard <= guard + 4'h1;
					end else if (guard == `SEP_GUARD_TICKS && rb_sync[1]) begin
						state <= SEP_HS_GAP;
					end
				end
				SEP_HS_GAP: begin
					if (tick) begin
						state <= SEP_HS_IDLE;
					end
				end
			endcase
		end
	end

	// Two-entry read buffer; a full buffer holds off new commands rather than losing a word.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr   <= 1'b0;
			rd_ptr   <= 1'b0;
			fifo_cnt <= 2'h0;
			fifo[0]  <= 16'h0000;
			fifo[1]  <= 16'h0000;
		end else begin
			if (push) begin
				fifo[wr_ptr] <= rd_sh[16:1];
				wr_ptr       <= ~wr_ptr;
			end
			if (rd_valid_o && rd_ready_i) begin
				rd_ptr <= ~rd_ptr;
			end
			fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, rd_valid_o && rd_ready_i};
		end
	end

	// Reset pin of the device follows the abort request one cycle later.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link.reset_pin <= 1'b0;
		end else begin
			link.reset_pin <= abort_i;
		end
	end

	assign rd_valid_o        = (fifo_cnt != 2'h0);
	assign rd_data_o         = fifo[rd_ptr];
	assign busy_o            = (state != SEP_HS_IDLE);
	assign link.chip_select  = cs;
	assign link.serial_clock = sclk;
	assign link.serial_in    = si;
endmodule
`default_nettype wire

// [sim/sep_assertions.sv]
// Concurrent checks on the pins that join the serial memory and its host controller.
`include "sep_consts.svh"
`default_nettype none
module sep_assertions #(
	parameter int unsigned PROG_CYCLES = `SEP_PROG_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic chip_select,
	input wire logic serial_clock,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic ready_busy,
	input wire logic reset_pin
);
	localparam logic [3:0] START_BITS = `SEP_START_PAT;
	logic        sclk_q;
	logic [5:0]  bit_cnt;
	int unsigned low_cnt;
	logic        abort_seen;
	logic        rise;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// A rise of the serial clock inside a frame is the moment the device takes a bit.
	assign rise = chip_select && serial_clock && !sclk_q;

	// Serial clock history.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= serial_clock;
		end
	end

	// Bits taken in the current frame; saturates so long frames cannot wrap back into the start field.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt <= 6'h00;
		end else if (!chip_select) begin
			bit_cnt <= 6'h00;
		end else if (rise && bit_cnt != 6'h3f) begin
			bit_cnt <= bit_cnt + 6'h01;
		end
	end

	// Length of the present busy phase, and whether an abort cut it short.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_cnt    <= 0;
			abort_seen <= 1'b0;
		end else begin
			low_cnt    <= ready_busy ? 0 : low_cnt + 1;
			abort_seen <= reset_pin || (abort_seen && !ready_busy);
		end
	end

	a_start_pattern: assert property (rise && bit_cnt < 6'h04 |-> serial_in == START_BITS[2'd3 - bit_cnt[1:0]])
		else $error("frame start field is not 1010");
	a_input_steady: assert property (chip_select && serial_clock && sclk_q |-> $stable(serial_in))
		else $error("serial input moved while the serial clock was high");
	a_output_on_fall: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> !serial_clock)
		else $error("serial output changed while the serial clock was high");
	a_dummy_lead: assert property ($rose(serial_out_oe) |-> chip_select && !serial_clock && !serial_out)
		else $error("read output did not open with a low dummy bit after a fall");
	a_oe_release: assert property (!chip_select [*6] |-> !serial_out_oe)
		else $error("serial output still driven after deselect");
	a_busy_launch: assert property ($fell(ready_busy) |-> chip_select && serial_clock)
		else $error("busy began away from a deciding clock rise");
	a_busy_bounded: assert property (!ready_busy |-> low_cnt <= PROG_CYCLES + 1)
		else $error("programming cycle ran past its time");
	a_busy_full: assert property ($rose(ready_busy) && !abort_seen |-> low_cnt + 1 >= PROG_CYCLES)
		else $error("ready returned before the programming time");
	a_clock_quiet: assert property (!ready_busy && !serial_clock |=> !serial_clock || ready_busy)
		else $error("serial clock toggled during programming");
	a_abort_halts: assert property (reset_pin [*6] |-> ready_busy && !serial_out_oe)
		else $error("reset pin did not halt the device");

	c_read_data: cover property ($rose(serial_out_oe));
	c_programming: cover property ($fell(ready_busy));
	c_abort: cover property (reset_pin [*6]);
endmodule
`default_nettype wire

// [sim/serial_eeprom_command_port_tb_top.sv]
// Self-checking bench joining the host and device ends of the serial memory port.
`include "sep_consts.svh"
`default_nettype none
`define SEP_CHK(what, exp, got) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("[ERR] %s expected %h seen %h", what, exp, got); \
		end \
	end
module serial_eeprom_command_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sep_pkg::*;
	// Short programming time keeps the run brief; the device and the assertion module both take it.
	localparam int unsigned PROG_C = 50;
	logic        clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, rd_valid_o, rd_ready_i, abort_i;
	logic        host_busy, dev_busy, prog_en;
	sep_op_t     cmd_op_i, last_op;
	logic [7:0]  cmd_addr_i;
	logic [15:0] cmd_data_i, rd_data_o;
	logic [31:0] in_bits;
	logic [16:0] out_bits;
	logic        sclk_q = 1'b0;
	logic        cs_q = 1'b0;
	int          in_cnt, out_cnt, busy_seen, mismatches, samples_checked;

	sep_if link_if ();
	sep_host sep_host_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if.host), .cmd_valid_i(cmd_valid_i),
		.cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
		.rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .abort_i(abort_i),
		.busy_o(host_busy)
	);
	sep_device #(.PROG_CYCLES(PROG_C)) sep_device_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if.dev), .busy_o(dev_busy),
		.prog_enabled_o(prog_en), .last_op_o(last_op)
	);
	sep_assertions #(.PROG_CYCLES(PROG_C)) sep_assertions_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select(link_if.chip_select),
		.serial_clock(link_if.serial_clock), .serial_in(link_if.serial_in), .serial_out(link_if.serial_out),
		.serial_out_oe(link_if.serial_out_oe), .ready_busy(link_if.ready_busy), .reset_pin(link_if.reset_pin)
	);

	// Free-running system clock.
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Capture each bit on a serial clock rise, so whole frames can be compared with the expected order.
	always @(posedge clk_i) begin
		if (link_if.chip_select && !cs_q) begin
			in_cnt = 0;
			out_cnt = 0;
			in_bits = '0;
			out_bits = '0;
		end
		if (link_if.chip_select && link_if.serial_clock && !sclk_q) begin
			if (link_if.serial_out_oe && out_cnt < 17) begin
				out_bits[out_cnt] = link_if.serial_out;
				out_cnt++;
			end else if (!link_if.serial_out_oe && in_cnt < 32) begin
				in_bits[in_cnt] = link_if.serial_in;
				in_cnt++;
			end
		end
		cs_q = link_if.chip_select;
		sclk_q = link_if.serial_clock;
		if (dev_busy === 1'b1) busy_seen++;
	end

	task automatic issue(input sep_op_t op, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		busy_seen = 0;
		cmd_op_i <= op;
		cmd_addr_i <= a;
		cmd_data_i <= d;
		cmd_valid_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (cmd_ready_o !== 1'b1 && n < 5000);
		cmd_valid_i <= 1'b0;
	endtask

	// Waits until the host is idle and the device shows ready, or 5000 cycles pass.
	task automatic settle();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((host_busy !== 1'b0 || link_if.ready_busy !== 1'b1) && n < 5000);
		`SEP_CHK("settle", 1'b1, n < 5000)
	endtask

	task automatic send(input sep_op_t op, input logic [7:0] a, input logic [15:0] d, input logic exp_busy);
		logic [3:0] opc;
		logic       long;
		case (op)
			SEP_OP_READ:    opc = `SEP_OPC_READ;
			SEP_OP_WRITE:   opc = `SEP_OPC_WRITE;
			SEP_OP_ENABLE:  opc = `SEP_OPC_ENABLE;
			SEP_OP_DISABLE: opc = `SEP_OPC_DISABLE;
			SEP_OP_ERASE:   opc = `SEP_OPC_ERASE;
			SEP_OP_FILL:    opc = `SEP_OPC_FILL;
			default:        opc = 4'hf; // Undefined opcode the host sends for no command.
		endcase
		long = (op == SEP_OP_WRITE || op == SEP_OP_FILL);
		issue(op, a, d);
		settle();
		`SEP_CHK("frame_bits", {long ? d : 16'h0000, a, opc[0], opc[1], opc[2], opc[3], 4'h5}, in_bits)
		`SEP_CHK("frame_len", long ? 32'h20 : 32'h10, in_cnt)
		`SEP_CHK("last_op", op, last_op)
		`SEP_CHK("busy_seen", exp_busy, busy_seen > 0)
	endtask

	task automatic pop(input logic [15:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rd_valid_o !== 1'b1 && n < 5000);
		`SEP_CHK("rd_data", exp, rd_data_o)
		rd_ready_i <= 1'b1;
		@(posedge clk_i);
		rd_ready_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		send(SEP_OP_READ, a, 16'h0000, 1'b0);
		`SEP_CHK("out_bits", {exp, 1'b0}, out_bits)
		`SEP_CHK("out_len", 32'h11, out_cnt)
		pop(exp);
	endtask

	task automatic test_done(input string name);
		$display("Test %s finished, mismatches so far %0d", name, mismatches);
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Main sequence: protection, programming, bulk commands, buffering, abort.
	initial begin
		rst_n_i = 1'b0;
		cmd_valid_i = 1'b0;
		cmd_op_i = SEP_OP_NONE;
		cmd_addr_i = 8'h00;
		cmd_data_i = 16'h0000;
		rd_ready_i = 1'b0;
		abort_i = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		`SEP_CHK("prog_en_reset", 1'b0, prog_en)
		`SEP_CHK("ready_reset", 1'b1, link_if.ready_busy)
		`SEP_CHK("oe_reset", 1'b0, link_if.serial_out_oe)
		send(SEP_OP_WRITE, 8'h10, 16'h0000, 1'b0);
		send(SEP_OP_ENABLE, 8'h00, 16'h0000, 1'b0);
		`SEP_CHK("prog_en_on", 1'b1, prog_en)
		send(SEP_OP_ERASE, 8'h00, 16'h0000, 1'b1);
		rd(8'h00, 16'hffff);
		rd(8'hff, 16'hffff);
		test_done("enable_erase");
		send(SEP_OP_WRITE, 8'h10, 16'h1234, 1'b1);
		send(SEP_OP_WRITE, 8'hff, 16'ha5c3, 1'b1);
		rd(8'h10, 16'h1234);
		rd(8'hff, 16'ha5c3);
		rd(8'h11, 16'hffff);
		test_done("word_write");
		send(SEP_OP_DISABLE, 8'h00, 16'h0000, 1'b0);
		`SEP_CHK("prog_en_off", 1'b0, prog_en)
		send(SEP_OP_WRITE, 8'h10, 16'h0000, 1'b0);
		send(SEP_OP_ERASE, 8'h00, 16'h0000, 1'b0);
		send(SEP_OP_FILL, 8'h00, 16'h5555, 1'b0);
		rd(8'h10, 16'h1234);
		test_done("protection");
		send(SEP_OP_ENABLE, 8'h00, 16'h0000, 1'b0);
		send(SEP_OP_ERASE, 8'h00, 16'h0000, 1'b1);
		send(SEP_OP_FILL, 8'h00, 16'h0f0f, 1'b1);
		rd(8'h00, 16'h0f0f);
		rd(8'h80, 16'h0f0f);
		rd(8'hff, 16'h0f0f);
		send(SEP_OP_NONE, 8'h00, 16'h0000, 1'b0);
		`SEP_CHK("none_keeps_en", 1'b1, prog_en)
		rd(8'h00, 16'h0f0f);
		test_done("bulk");
		// Two unread words fill the buffer, so a third command must wait.
		send(SEP_OP_WRITE, 8'h10, 16'h3c3c, 1'b1);
		issue(SEP_OP_READ, 8'h10, 16'h0000);
		settle();
		issue(SEP_OP_READ, 8'h80, 16'h0000);
		settle();
		cmd_op_i <= SEP_OP_READ;
		cmd_addr_i <= 8'hff;
		cmd_valid_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		`SEP_CHK("stall_ready", 1'b0, cmd_ready_o)
		cmd_valid_i <= 1'b0;
		pop(16'h3c3c);
		pop(16'h0f0f);
		rd(8'hff, 16'h0f0f);
		test_done("buffer");
		issue(SEP_OP_WRITE, 8'h20, 16'h0000);
		for (int n = 0; n < 5000 && dev_busy !== 1'b1; n++) @(posedge clk_i);
		abort_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		`SEP_CHK("abort_ready", 1'b1, link_if.ready_busy)
		`SEP_CHK("abort_busy", 1'b0, dev_busy)
		abort_i <= 1'b0;
		settle();
		`SEP_CHK("abort_keeps_en", 1'b1, prog_en)
		rd(8'h20, 16'hffff);
		test_done("abort");
		final_report();
	end

	// Cuts a hang short well beyond the expected length of the run.
	initial begin
		repeat (80000) @(posedge clk_i);
		mismatches++;
		$display("[ERR] watchdog expected %h seen %h", 1'b1, 1'b0);
		final_report();
	end
endmodule
`default_nettype wire
